// ### rtl/ext_irq_pkg.sv
// package of the external interrupt and vector block: register indices, field
// positions, reset values, vector addresses, modes and bus carriers.
// assumes a 32-bit axi4-lite bus with an 8-bit byte address.
package ext_irq_pkg;

   // ----------------------------------------------------------------------
   // bus widths and carriers
   // ----------------------------------------------------------------------
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;

   typedef struct packed {
      logic awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [AXI_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_type;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [7:0] IDX_PC_MASK_LOW = 8'h12;
   localparam logic [7:0] IDX_PC_MASK_HIGH = 8'h20;
   localparam logic [7:0] IDX_MCU_CTRL = 8'h35;
   localparam logic [7:0] IDX_INT_FLAG = 8'h3A;
   localparam logic [7:0] IDX_INT_EN = 8'h3B;
   localparam logic [7:0] IDX_CORE_STATUS = 8'h3C;

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int SENSE_LO_BIT = 0;
   localparam int SENSE_HI_BIT = 1;
   localparam int SLEEP_MODE_LO_BIT = 3;
   localparam int SLEEP_MODE_HI_BIT = 4;
   localparam int SLEEP_EN_BIT = 5;
   localparam int EXT_BIT = 6;
   localparam int PC_HIGH_BIT = 5;
   localparam int PC_LOW_BIT = 4;
   localparam logic [7:0] MCU_CTRL_RST = 8'h00;
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] INT_EN_WMASK = 8'h70;
   localparam logic [7:0] PC_MASK_LOW_RST = 8'h00;
   localparam logic [3:0] PC_MASK_HIGH_RST = 4'h0;

   // ----------------------------------------------------------------------
   // modes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_ANY = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_type;

   localparam logic [1:0] SLEEP_MODE_IDLE = 2'h0;

   typedef enum logic [1:0] {
      PS_RUN = 2'h0,
      PS_SLEEP = 2'h1,
      PS_START = 2'h3
   } power_state_type;

   // ----------------------------------------------------------------------
   // vector word addresses, lowest address has highest priority
   // ----------------------------------------------------------------------
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_EXT = 16'h0001;
   localparam logic [15:0] VEC_PC_LOW = 16'h0002;
   localparam logic [15:0] VEC_PC_HIGH = 16'h0003;
   localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
   localparam logic [15:0] VEC_TIMER16_CAPTURE = 16'h0005;
   localparam logic [15:0] VEC_TIMER8_OVERFLOW = 16'h000B;
   localparam logic [15:0] VEC_COMPARATOR = 16'h000C;
   localparam logic [15:0] VEC_SERIAL_OVERFLOW = 16'h0010;
   localparam int VEC_COUNT = 17;
   localparam int PERIPH_COUNT = 13;

endpackage

// ### rtl/pin_change_group.sv
// toggle detector for one group of pin-change inputs.
// assumes pins are synchronous to clock and that clock keeps running in sleep.
`timescale 1ns/100ps
module pin_change_group #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pins,
   input wire logic [WIDTH-1:0] mask,
   output logic hit_r
);

   logic [WIDTH-1:0] prev_r;
   logic primed_r;

   // ----------------------------------------------------------------------
   // toggle capture
   // ----------------------------------------------------------------------
   // previous level; primed blocks a false toggle from the reset value
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
         primed_r <= 1'b0;
      end else begin
         prev_r <= pins;
         primed_r <= 1'b1;
      end
   end

   // not gated by the i/o clock, so a toggle can wake any sleep mode
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= primed_r & (|((pins ^ prev_r) & mask));
      end
   end

endmodule

// ### rtl/ext_irq_ctrl.sv
// external interrupt pin, two pin-change groups, vector selection and sleep
// wake control, with its registers behind an axi4-lite slave.
// assumes pins synchronous to clock; peripheral requests arrive pre-enabled.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module ext_irq_ctrl
   import ext_irq_pkg::*;
#(
   parameter int STARTUP_CYCLES = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire axi_req_type axi_req,
   output axi_rsp_type axi_rsp,
   input wire logic ext_irq_pin,
   input wire logic [11:0] pin_change_inputs,
   input wire logic [PERIPH_COUNT-1:0] periph_req,
   input wire logic global_irq_en,
   input wire logic sleep_cmd,
   input wire logic vec_taken,
   output logic irq_valid_r,
   output logic [15:0] irq_vector_r,
   output logic boot_fetch_r,
   output logic io_clk_run_r,
   output logic asleep_r
);

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // word index from a byte address; low two bits ignored
   function automatic logic [7:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
      return {2'h0, addr[7:2]};
   endfunction

   // lowest set bit wins, so lower vector addresses take priority
   function automatic logic [4:0] first_req(input logic [VEC_COUNT-1:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = VEC_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [AXI_ADDR_W-1:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wstrb_r;
   logic [1:0] bresp_r, rresp_r, rresp_nxt;
   logic [AXI_DATA_W-1:0] rdata_r, rdata_nxt;
   logic [7:0] mcu_ctrl_r, int_en_r, pc_mask_low_r;
   logic [3:0] pc_mask_high_r;
   logic ext_flag_r, pc_low_flag_r, pc_high_flag_r;
   logic pin_q_r, pin_prev_r;
   logic hit_low, hit_high;
   logic wr_fire, wr_hit, ar_fire;
   logic [7:0] wr_idx, flag_w1c;
   sense_type sense;
   logic rise, fall, edge_hit, level_low;
   logic ext_req, pc_low_req, pc_high_req, pend_any;
   logic [VEC_COUNT-1:0] req_vec;
   logic [4:0] req_idx;
   logic clr_ext, clr_low, clr_high;
   power_state_type pstate_r, pstate_nxt;
   logic [1:0] sleep_mode_r;
   logic [15:0] start_cnt_r;

   // ----------------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------------
   assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                      bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                      rdata: rdata_r, rresp: rresp_r};
   assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
   assign wr_idx = reg_index(awaddr_r);
   assign wr_hit = (wr_idx == IDX_PC_MASK_LOW) | (wr_idx == IDX_PC_MASK_HIGH) |
                   (wr_idx == IDX_MCU_CTRL) | (wr_idx == IDX_INT_FLAG) |
                   (wr_idx == IDX_INT_EN) | (wr_idx == IDX_CORE_STATUS);
   assign ar_fire = axi_req.arvalid & arready_r;

   // address and data taken in either order; ready drops until response
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         awaddr_r <= '0;
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
      end else begin
         if (axi_req.awvalid & awready_r) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= axi_req.awaddr;
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
         end
         if (axi_req.wvalid & wready_r) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= axi_req.wdata[7:0];
            wstrb_r <= axi_req.wstrb[0];
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
         end
         if (bvalid_r & axi_req.bready) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // write response; unmapped index answers decerr
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (axi_req.bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read mux, registers sit in the low byte
   always_comb begin
      rdata_nxt = '0;
      rresp_nxt = RESP_OKAY;
      unique case (reg_index(axi_req.araddr))
         IDX_PC_MASK_LOW: rdata_nxt[7:0] = pc_mask_low_r;
         IDX_PC_MASK_HIGH: rdata_nxt[3:0] = pc_mask_high_r;
         IDX_MCU_CTRL: rdata_nxt[7:0] = mcu_ctrl_r;
         IDX_INT_EN: rdata_nxt[7:0] = int_en_r;
         IDX_INT_FLAG: begin
            rdata_nxt[EXT_BIT] = ext_flag_r;
            rdata_nxt[PC_HIGH_BIT] = pc_high_flag_r;
            rdata_nxt[PC_LOW_BIT] = pc_low_flag_r;
         end
         IDX_CORE_STATUS: rdata_nxt[2:0] = {io_clk_run_r, asleep_r, pin_q_r};
         default: rresp_nxt = RESP_DECERR;
      endcase
   end

   // one read in flight; arready drops until the data are taken
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end else if (rvalid_r & axi_req.rready) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   // byte lane 0 carries every register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mcu_ctrl_r <= MCU_CTRL_RST;
         int_en_r <= INT_EN_RST;
         pc_mask_low_r <= PC_MASK_LOW_RST;
         pc_mask_high_r <= PC_MASK_HIGH_RST;
      end else if (wr_fire & wstrb_r) begin
         if (wr_idx == IDX_MCU_CTRL) begin
            mcu_ctrl_r <= wdata_r;
         end
         if (wr_idx == IDX_INT_EN) begin
            int_en_r <= wdata_r & INT_EN_WMASK;
         end
         if (wr_idx == IDX_PC_MASK_LOW) begin
            pc_mask_low_r <= wdata_r;
         end
         if (wr_idx == IDX_PC_MASK_HIGH) begin
            pc_mask_high_r <= wdata_r[3:0];
         end
      end
   end

   assign flag_w1c = (wr_fire & wstrb_r & (wr_idx == IDX_INT_FLAG)) ? wdata_r : 8'h00;

   // ----------------------------------------------------------------------
   // external pin sensing
   // ----------------------------------------------------------------------
   // pad level is read whatever the pin direction, so software can self-trigger
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_q_r <= 1'b1;
         pin_prev_r <= 1'b1;
      end else begin
         pin_q_r <= ext_irq_pin;
         pin_prev_r <= pin_q_r;
      end
   end

   assign sense = sense_type'({mcu_ctrl_r[SENSE_HI_BIT], mcu_ctrl_r[SENSE_LO_BIT]});
   assign rise = pin_q_r & ~pin_prev_r;
   assign fall = ~pin_q_r & pin_prev_r;
   assign level_low = (sense == SENSE_LOW) & ~pin_q_r;

   // edges need the i/o clock; the level path does not
   always_comb begin
      edge_hit = 1'b0;
      unique case (sense)
         SENSE_LOW: edge_hit = 1'b0;
         SENSE_ANY: edge_hit = rise | fall;
         SENSE_FALL: edge_hit = fall;
         SENSE_RISE: edge_hit = rise;
      endcase
      edge_hit = edge_hit & io_clk_run_r;
   end

   // ----------------------------------------------------------------------
   // pin-change groups
   // ----------------------------------------------------------------------
   pin_change_group #(.WIDTH(8)) u_group_low (
      .clock(clock),
      .rst(rst),
      .pins(pin_change_inputs[7:0]),
      .mask(pc_mask_low_r),
      .hit_r(hit_low)
   );

   pin_change_group #(.WIDTH(4)) u_group_high (
      .clock(clock),
      .rst(rst),
      .pins(pin_change_inputs[11:8]),
      .mask(pc_mask_high_r),
      .hit_r(hit_high)
   );

   // ----------------------------------------------------------------------
   // pending flags
   // ----------------------------------------------------------------------
   assign clr_ext = (vec_taken & irq_valid_r & (irq_vector_r == VEC_EXT)) | flag_w1c[EXT_BIT];
   assign clr_low = (vec_taken & irq_valid_r & (irq_vector_r == VEC_PC_LOW)) |
                    flag_w1c[PC_LOW_BIT];
   assign clr_high = (vec_taken & irq_valid_r & (irq_vector_r == VEC_PC_HIGH)) |
                     flag_w1c[PC_HIGH_BIT];

   // set beats clear in the same cycle so no event is lost
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_flag_r <= 1'b0;
         pc_low_flag_r <= 1'b0;
         pc_high_flag_r <= 1'b0;
      end else begin
         if (sense == SENSE_LOW) begin
            ext_flag_r <= 1'b0;
         end else begin
            ext_flag_r <= edge_hit | (ext_flag_r & ~clr_ext);
         end
         pc_low_flag_r <= hit_low | (pc_low_flag_r & ~clr_low);
         pc_high_flag_r <= hit_high | (pc_high_flag_r & ~clr_high);
      end
   end

   // ----------------------------------------------------------------------
   // request gating and vector choice
   // ----------------------------------------------------------------------
   // level request follows the pin directly, no flag involved
   assign ext_req = int_en_r[EXT_BIT] &
                    ((sense == SENSE_LOW) ? level_low : ext_flag_r);
   assign pc_low_req = int_en_r[PC_LOW_BIT] & pc_low_flag_r;
   assign pc_high_req = int_en_r[PC_HIGH_BIT] & pc_high_flag_r;
   // slot 0 is the reset vector and is never requested here
   assign req_vec = {periph_req, pc_high_req, pc_low_req, ext_req, 1'b0};
   assign pend_any = |req_vec;
   assign req_idx = first_req(req_vec);

   // vector presented only while running; sleeping core cannot take it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_valid_r <= 1'b0;
         irq_vector_r <= VEC_RESET;
         boot_fetch_r <= 1'b1;
      end else begin
         boot_fetch_r <= 1'b0;
         irq_valid_r <= pend_any & global_irq_en & (pstate_r == PS_RUN) & ~vec_taken;
         irq_vector_r <= {11'h000, req_idx};
      end
   end

   // ----------------------------------------------------------------------
   // sleep and start-up sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      pstate_nxt = pstate_r;
      unique case (pstate_r)
         PS_RUN: begin
            if (sleep_cmd & mcu_ctrl_r[SLEEP_EN_BIT]) begin
               pstate_nxt = PS_SLEEP;
            end
         end
         PS_SLEEP: begin
            if (pend_any) begin
               pstate_nxt = (sleep_mode_r == SLEEP_MODE_IDLE) ? PS_RUN : PS_START;
            end
         end
         PS_START: begin
            // level may vanish here: run resumes, no vector appears
            if (start_cnt_r == 16'(STARTUP_CYCLES - 1)) begin
               pstate_nxt = PS_RUN;
            end
         end
         default: pstate_nxt = PS_RUN;
      endcase
   end

   // mode latched on entry so a later write cannot alter this sleep
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pstate_r <= PS_RUN;
         sleep_mode_r <= SLEEP_MODE_IDLE;
         start_cnt_r <= 16'h0000;
         asleep_r <= 1'b0;
         io_clk_run_r <= 1'b1;
      end else begin
         pstate_r <= pstate_nxt;
         if (pstate_r == PS_RUN) begin
            sleep_mode_r <= mcu_ctrl_r[SLEEP_MODE_HI_BIT:SLEEP_MODE_LO_BIT];
         end
         start_cnt_r <= (pstate_r == PS_START) ? start_cnt_r + 16'h0001 : 16'h0000;
         asleep_r <= (pstate_nxt != PS_RUN);
         io_clk_run_r <= (pstate_nxt == PS_RUN) | (pstate_nxt == PS_SLEEP & ((pstate_r == PS_RUN) ?
                         mcu_ctrl_r[SLEEP_MODE_HI_BIT:SLEEP_MODE_LO_BIT] : sleep_mode_r)
                         == SLEEP_MODE_IDLE);
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence level_held;
      (int_en_r[EXT_BIT] & level_low & global_irq_en & pstate_r == PS_RUN & ~vec_taken)[*2];
   endsequence

   chk_level_flag_clear: assert property ((sense == SENSE_LOW) |=> !ext_flag_r)
      else $error("pin flag set in level mode");
   chk_low_group_set: assert property (hit_low |=> pc_low_flag_r)
      else $error("low group toggle lost");
   chk_high_group_set: assert property (hit_high |=> pc_high_flag_r)
      else $error("high group toggle lost");
   chk_mask_blocks_hit: assert property ((pc_mask_low_r == 8'h00) |=> !hit_low)
      else $error("masked pin raised a hit");
   chk_global_gate: assert property (irq_valid_r |-> $past(global_irq_en))
      else $error("request without global enable");
   chk_edge_clock_off: assert property (
      (!io_clk_run_r && sense != SENSE_LOW && !ext_flag_r) |=> !ext_flag_r)
      else $error("edge seen with i/o clock stopped");
   chk_sleep_clock_stop: assert property (
      (pstate_r != PS_RUN && sleep_mode_r != SLEEP_MODE_IDLE) |-> !io_clk_run_r)
      else $error("i/o clock running in deep sleep");
   chk_boot_vector: assert property (
      boot_fetch_r |-> irq_vector_r == VEC_RESET && !irq_valid_r)
      else $error("boot fetch not at reset vector");
   chk_level_request: assert property (
      level_held |-> irq_valid_r && irq_vector_r == VEC_EXT)
      else $error("held low level not requested");
   chk_level_wake: assert property (
      (pstate_r == PS_SLEEP && int_en_r[EXT_BIT] && level_low) |=> pstate_r != PS_SLEEP)
      else $error("low level did not wake");
   chk_fall_flag: assert property (
      (sense == SENSE_FALL && io_clk_run_r && fall) |=> ext_flag_r)
      else $error("falling edge missed");

endmodule

// ### dv/core_seq_model.sv
// core vector sequencer model: takes each presented vector.
// assumes the vector stands until vec_taken; ext_irq_ctrl re-registers valid and vector from the requests every cycle.
`timescale 1ns/100ps
module core_seq_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic irq_valid_r,
   input wire logic [15:0] irq_vector_r,
   input wire logic [3:0] slow,
   output logic vec_taken,
   output logic [15:0] taken_vec
);
   logic [3:0] wait_r;
   // waits slow cycles, skips the cycle after a take while valid drops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vec_taken <= 1'b0;
         taken_vec <= 16'h0000;
         wait_r <= 4'h0;
      end else begin
         vec_taken <= 1'b0;
         if (irq_valid_r && !vec_taken) begin
            wait_r <= (wait_r == slow) ? 4'h0 : wait_r + 4'h1;
            if (wait_r == slow) begin
               vec_taken <= 1'b1;
               taken_vec <= irq_vector_r;
            end
         end
      end
   end
endmodule

// ### dv/ext_pin_interrupt_vectors_tb.sv
// bench of ext_irq_ctrl: axi4-lite tasks, pin stimulus, sequencer model.
// assumes one clock; sleep is entered through the sleep command input.
`timescale 1ns/100ps
module ext_pin_interrupt_vectors_tb;
   import ext_irq_pkg::*;
   logic clock = 0, rst = 1, pin = 1, gie = 0, slp = 0, vt, boot, ivalid, io_run, asleep;
   logic [11:0] pcin = 12'h000;
   logic [12:0] preq = 13'h0000;
   logic [15:0] ivec, tv;
   logic [3:0] slow = 4'h0;
   logic [31:0] d;
   logic [1:0] r;
   int mismatches = 0, n_compared = 0, cycles = 0, k;
   sense_type modes[3] = '{SENSE_FALL, SENSE_RISE, SENSE_ANY};
   axi_req_type req = '0;
   axi_rsp_type rsp;
   initial forever #5 clock = ~clock;
   ext_irq_ctrl #(.STARTUP_CYCLES(2)) dut (.clock(clock), .rst(rst), .axi_req(req),
      .axi_rsp(rsp), .ext_irq_pin(pin), .pin_change_inputs(pcin), .periph_req(preq),
      .global_irq_en(gie), .sleep_cmd(slp), .vec_taken(vt), .irq_valid_r(ivalid),
      .irq_vector_r(ivec), .boot_fetch_r(boot), .io_clk_run_r(io_run), .asleep_r(asleep));
   core_seq_model seq (.clock(clock), .rst(rst), .irq_valid_r(ivalid), .irq_vector_r(ivec),
      .slow(slow), .vec_taken(vt), .taken_vec(tv));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // hold each channel until its own ready edge
   task wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] resp);
      @(posedge clock);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx[5:0], 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, v};
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(posedge clock);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      resp = rsp.bresp;
   endtask
   task rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
      @(posedge clock);
      req.arvalid <= 1'b1;
      req.araddr <= {idx[5:0], 2'b00};
      req.rready <= 1'b1;
      do begin
         @(posedge clock);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
      v = rsp.rdata;
      resp = rsp.rresp;
   endtask
   task exp_vec(input logic [15:0] v);
      for (int i = 0; i < 40 && vt !== 1'b1; i++) @(posedge clock);
      // a take that never came fails here, not through a stale vector
      chk({15'h0000, vt, tv}, {15'h0000, 1'b1, v});
      @(posedge clock);
   endtask
   // two settling edges, then any request in six cycles is a fault
   task quiet;
      logic seen;
      seen = 1'b0;
      repeat (2) @(posedge clock);
      repeat (6) begin
         @(posedge clock);
         seen = seen | ivalid;
      end
      chk({31'h0, seen}, 32'h0);
   endtask
   task nap;
      slp <= 1'b1;
      @(posedge clock);
      slp <= 1'b0;
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         finish_test;
      end
   end
   initial begin
      repeat (4) @(posedge clock);
      chk({15'h0, boot, ivec}, 32'h00010000);
      rst <= 1'b0;
      rd(IDX_MCU_CTRL, d, r);
      chk(d, {24'h0, MCU_CTRL_RST});
      wr(IDX_PC_MASK_HIGH, 8'hFF, r);
      rd(IDX_PC_MASK_HIGH, d, r);
      chk(d, 32'h0000000F);
      rd(8'h3F, d, r);
      chk({30'h0, r}, {30'h0, RESP_DECERR});
      $display("registers done");
      gie <= 1'b1;
      wr(IDX_INT_EN, 8'h40, r);
      for (k = 0; k < 3; k++) begin
         wr(IDX_MCU_CTRL, {6'h00, modes[k]}, r);
         pin <= ~pin;
         exp_vec(VEC_EXT);
      end
      rd(IDX_INT_FLAG, d, r);
      chk(d, 32'h0);
      wr(IDX_MCU_CTRL, {6'h00, SENSE_LOW}, r);
      exp_vec(VEC_EXT);
      exp_vec(VEC_EXT);
      rd(IDX_INT_FLAG, d, r);
      chk(d, 32'h0);
      pin <= 1'b1;
      quiet;
      $display("pin modes done");
      wr(IDX_INT_EN, 8'h30, r);
      wr(IDX_PC_MASK_LOW, 8'h08, r);
      wr(IDX_PC_MASK_HIGH, 8'h02, r);
      pcin <= pcin ^ 12'h004;
      quiet;
      gie <= 1'b0;
      pcin <= pcin ^ 12'h008;
      quiet;
      gie <= 1'b1;
      exp_vec(VEC_PC_LOW);
      pcin <= pcin ^ 12'h200;
      exp_vec(VEC_PC_HIGH);
      pcin <= pcin ^ 12'h100;
      pin <= 1'b0;
      quiet;
      $display("pin change done");
      slow <= 4'h3;
      for (k = 0; k < PERIPH_COUNT; k++) begin
         preq <= 13'h0001 << k;
         exp_vec(VEC_WATCHDOG + 16'(k));
         preq <= 13'h0000;
         repeat (4) @(posedge clock);
      end
      $display("vectors done");
      pin <= 1'b1;
      wr(IDX_MCU_CTRL, 8'h32, r); // sleep enabled, deep mode, falling edge
      wr(IDX_INT_EN, 8'h40, r);
      nap;
      pin <= 1'b0;
      rd(IDX_CORE_STATUS, d, r);
      chk(d, 32'h00000002);
      chk({30'h0, io_run, asleep}, 32'h00000001);
      wr(IDX_MCU_CTRL, 8'h30, r);
      exp_vec(VEC_EXT);
      pin <= 1'b1;
      repeat (2) @(posedge clock);
      nap;
      // low level gone before start-up ends
      pin <= 1'b0;
      @(posedge clock);
      pin <= 1'b1;
      quiet;
      rd(IDX_CORE_STATUS, d, r);
      chk(d, 32'h00000005);
      $display("sleep done");
      finish_test;
   end
endmodule
